// [rtl/sasc_defs.svh]
// Register map, reset values and error constants of the averaging setup controller.
// Behaviour
// - A filter-clear command empties the filter history in manual and automatic length mode.
// - Filter-clear while list mode is active reports error -221.
// - Auto length with step detection: newest-four mean off whole mean by >12.5% clears.
// - Auto trigger delay on and continuous initiate off masks step detection, setting kept.
// - Step detection resets on; reads back 1 when on, 0 when off.
// - Averaging enable resets on; reads back 1 when on, 0 when off.
// - Turning averaging on at fast measurement rate reports error -221.
// - Turning averaging on during list mode reports -221, cause list mode running.
// - Video bandwidth low 300 kHz, medium 1.5 MHz, high 5 MHz, off 5 MHz.
// - Low, medium or high switch the flattening filter in; off bypasses all corrections.
// - Video bandwidth selector resets to off.
// - Video bandwidth enable resets off; reads back 1 when on, 0 when off.
// - Writing bandwidth selector or enable under mean-only detection reports -221.
// - Buffer count accepts 1 to 60001; outside is clipped and -222 reported.
// - Writing buffer count without external trigger reports -221, invalid acquisition mode.
// - Nonzero frequency step drives buffer count; writing the count then reports -221.
// - Buffer count resets to 1.
// - Buffer type is mean, peak, peak-to-mean or minimum, resets mean; else -224.
// - Writing buffer type without external trigger or under mean detection reports -221.
// - Enabling offset table with none selected reports -221 and stays off.
// - Enabling gamma table with none selected reports -221 and stays off.
// - Gamma table on while single gamma on forces single off and reports -221.
`ifndef SASC_DEFS_SVH
`define SASC_DEFS_SVH
`define SASC_OFS_FILT_CLR 8'h00
`define SASC_OFS_STEP_DET 8'h04
`define SASC_OFS_AVG_EN 8'h08
`define SASC_OFS_VBW_SEL 8'h0c
`define SASC_OFS_VBW_EN 8'h10
`define SASC_OFS_BUF_CNT 8'h14
`define SASC_OFS_BUF_TYPE 8'h18
`define SASC_OFS_OFS_TBL 8'h1c
`define SASC_OFS_GAM_TBL 8'h20
`define SASC_OFS_SGL_GAM 8'h24
`define SASC_OFS_CONTEXT 8'h28
`define SASC_OFS_FREQUENCY_STEP 8'h2c
`define SASC_OFS_ERR_POP 8'h30
`define SASC_OFS_STATUS 8'h34
`define SASC_OFS_VBW_KHZ 8'h38
`define SASC_OFS_FILT_SUM 8'h3c
`define SASC_CTX_RST 9'h004
`define SASC_BUF_MIN 16'h0001
`define SASC_BUF_MAX 16'hea61
`define SASC_ERR_CONFLICT 8'hdd
`define SASC_ERR_CLIPPED 8'hde
`define SASC_ERR_ILLEGAL 8'he0
`define SASC_KHZ_LOW 13'h012c
`define SASC_KHZ_MED 13'h05dc
`define SASC_KHZ_HIGH 13'h1388
`define SASC_FILT_MAX 9'h100
`define SASC_STEP_MIN 9'h004
`define SASC_QUEUE_DEPTH 4'h8
`endif

// [rtl/sasc_pkg.sv]
// Types of the averaging setup controller and of its error queue entries.
package sasc_pkg;
  typedef logic [1:0] sasc_vbw_t;
  localparam sasc_vbw_t SASC_VBW_OFF = 2'h0;
  localparam sasc_vbw_t SASC_VBW_LOW = 2'h1;
  localparam sasc_vbw_t SASC_VBW_MED = 2'h2;
  localparam sasc_vbw_t SASC_VBW_HIGH = 2'h3;
  typedef logic [3:0] sasc_cause_t;
  localparam sasc_cause_t SASC_CAUSE_CONFLICT = 4'h1;
  localparam sasc_cause_t SASC_CAUSE_LIST_RUN = 4'h2;
  localparam sasc_cause_t SASC_CAUSE_ACQ_MODE = 4'h3;
  localparam sasc_cause_t SASC_CAUSE_SWEEP = 4'h4;
  localparam sasc_cause_t SASC_CAUSE_SGL_OFF = 4'h5;
  localparam sasc_cause_t SASC_CAUSE_CLIPPED = 4'h6;
  localparam sasc_cause_t SASC_CAUSE_ILLEGAL = 4'h7;
  typedef struct packed {
    logic listMode;
    logic rateFast;
    logic detMean;
    logic trigExt;
    logic autoTrigDelay;
    logic contInit;
    logic autoLength;
    logic ofsTblSel;
    logic gamTblSel;
  } sasc_ctx_s;
  typedef struct packed {
    logic push;
    sasc_cause_t cause;
    logic [7:0] code;
  } sasc_err_s;
endpackage : sasc_pkg

// [rtl/sasc_mem_if.sv]
// Port bundle between the controller and its error queue memory.
`timescale 1ns/10ps
interface sasc_mem_if;
  logic wrEn;
  logic [2:0] wrAddr;
  logic [11:0] wrData;
  logic [2:0] rdAddr;
  logic [11:0] rdData;
  modport ctrl(output wrEn, output wrAddr, output wrData, output rdAddr, input rdData);
  modport mem(input wrEn, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : sasc_mem_if

// [rtl/sasc_err_mem.sv]
// Eight-entry storage of the error queue with registered read data.
`timescale 1ns/10ps
module sasc_err_mem (
  input wire logic clk, // System clock.
  sasc_mem_if.mem m // Write and read ports.
);
  logic [11:0] memArr [0:7];
  logic [11:0] rdDataFf;
  logic [11:0] nxt_rdData;

  // A write to the entry being read is passed through so a fresh error is seen at once.
  always_comb begin
    nxt_rdData = memArr[m.rdAddr];
    if (m.wrEn && (m.wrAddr == m.rdAddr)) begin
      nxt_rdData = m.wrData;
    end
  end

  // Storage has no reset; only entries between the pointers are ever read.
  always_ff @(posedge clk) begin
    if (m.wrEn) begin
      memArr[m.wrAddr] <= m.wrData;
    end
    rdDataFf <= nxt_rdData;
  end

  assign m.rdData = rdDataFf;
endmodule : sasc_err_mem

// [rtl/sasc_top.sv]
// Averaging, video bandwidth, buffer and correction settings with conflict checks.
//
// Added by the designer: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
`include "sasc_defs.svh"
module sasc_top import sasc_pkg::*; (
  input wire logic clk, // System clock, 40 MHz.
  input wire logic reset, // Synchronous reset, active high.
  input wire logic [7:0] address, // Avalon byte address.
  input wire logic read, // Avalon read request.
  input wire logic write, // Avalon write request.
  input wire logic [31:0] writedata, // Avalon write data.
  output logic [31:0] readdata, // Avalon read data.
  output logic waitrequest, // Avalon stall.
  input wire logic sampleValid, // New measurement for the filter.
  input wire logic [15:0] sampleData, // Measurement value.
  output logic [23:0] filterSum, // Accumulated filter sum.
  output logic [8:0] filterCount, // Entries in the filter.
  output logic avgOn, // Averaging enabled.
  output logic stepActive, // Step detection in effect.
  output logic firFilterOn, // Flattening filter switched in.
  output logic correctionBypass, // All corrections bypassed.
  output logic [12:0] vbwKhz, // Video bandwidth in kHz.
  output logic videoBwOn, // Video bandwidth enable.
  output logic [15:0] bufCount, // Buffered sample count.
  output logic [1:0] bufType, // Buffered measurement type.
  output logic offsetTableOn, // Offset-table correction on.
  output logic gammaTableOn, // Gamma-table correction on.
  output logic singleGammaOn // Single-point gamma on.
);
  // Clip a written count into the accepted range.
  function automatic logic [15:0] clipCount(input logic [31:0] v);
    if (v < 32'({`SASC_BUF_MIN})) begin
      return `SASC_BUF_MIN;
    end else if (v > 32'({`SASC_BUF_MAX})) begin
      return `SASC_BUF_MAX;
    end
    return v[15:0];
  endfunction : clipCount

  // Build one error queue entry.
  function automatic sasc_err_s mkErr(input logic [7:0] code, input sasc_cause_t cause);
    sasc_err_s e;
    e.push = 1'b1;
    e.cause = cause;
    e.code = code;
    return e;
  endfunction : mkErr

  // Bandwidth figure of a selector code.
  // bandwidth figure map
  function automatic logic [12:0] bwKhz(input sasc_vbw_t s);
    unique case (s)
      SASC_VBW_LOW: return `SASC_KHZ_LOW;
      SASC_VBW_MED: return `SASC_KHZ_MED;
      SASC_VBW_HIGH: return `SASC_KHZ_HIGH;
      SASC_VBW_OFF: return `SASC_KHZ_HIGH;
    endcase
  endfunction : bwKhz

  logic ackFf, nxt_ack;
  logic [31:0] readdataFf, nxt_readdata;
  logic avgEnFf, nxt_avgEn, stepDetFf, nxt_stepDet, vbwEnFf, nxt_vbwEn;
  sasc_vbw_t vbwSelFf, nxt_vbwSel;
  logic [15:0] bufCntFf, nxt_bufCnt, freqStepFf, nxt_freqStep;
  logic [1:0] bufTypeFf, nxt_bufType;
  logic ofsTblFf = 1'b0;
  logic gamTblFf = 1'b0;
  logic nxt_ofsTbl, nxt_gamTbl, sglGamFf, nxt_sglGam;
  sasc_ctx_s ctxFf, nxt_ctx;
  logic [12:0] vbwKhzFf, nxt_vbwKhz;
  logic filtClear, wrGo, rdGo, pop, stepHit;
  sasc_err_s errIn;
  logic [23:0] sumFf, nxt_sum;
  logic [8:0] cntFf, nxt_cnt;
  logic [63:0] lastFf, nxt_last;
  logic [2:0] headFf, nxt_head, tailFf, nxt_tail;
  logic [3:0] qCntFf, nxt_qCnt;
  logic [17:0] newest4;
  logic [27:0] crossA, crossB, crossDiff;
  sasc_mem_if memBus();

  // Every access takes one stall cycle, so read data always come from a flip-flop.
  assign wrGo = write && ackFf;
  assign rdGo = read && ackFf;
  assign waitrequest = !ackFf;

  // Bus handshake and read-back mux.
  always_comb begin
    nxt_ack = (read || write) && !ackFf;
    nxt_readdata = readdataFf;
    if (nxt_ack && read) begin
      unique case (address)
        `SASC_OFS_STEP_DET: nxt_readdata = {31'h0, stepDetFf};
        `SASC_OFS_AVG_EN: nxt_readdata = {31'h0, avgEnFf};
        `SASC_OFS_VBW_SEL: nxt_readdata = {30'h0, vbwSelFf};
        `SASC_OFS_VBW_EN: nxt_readdata = {31'h0, vbwEnFf};
        `SASC_OFS_BUF_CNT: nxt_readdata = {16'h0, bufCntFf};
        `SASC_OFS_BUF_TYPE: nxt_readdata = {30'h0, bufTypeFf};
        `SASC_OFS_OFS_TBL: nxt_readdata = {31'h0, ofsTblFf};
        `SASC_OFS_GAM_TBL: nxt_readdata = {31'h0, gamTblFf};
        `SASC_OFS_SGL_GAM: nxt_readdata = {31'h0, sglGamFf};
        `SASC_OFS_CONTEXT: nxt_readdata = {23'h0, ctxFf};
        `SASC_OFS_FREQUENCY_STEP: nxt_readdata = {16'h0, freqStepFf};
        `SASC_OFS_ERR_POP: begin
          // Empty queue reads as zero, meaning no error.
          if (qCntFf == 4'h0) begin
            nxt_readdata = 32'h0;
          end else begin
            nxt_readdata = {12'h0, memBus.rdData[11:8],
                            16'(-{8'h0, memBus.rdData[7:0]})};
          end
        end
        `SASC_OFS_STATUS: nxt_readdata = {25'h0, firFilterOn, stepActive, 1'b0, qCntFf};
        `SASC_OFS_VBW_KHZ: nxt_readdata = {19'h0, vbwKhzFf};
        `SASC_OFS_FILT_SUM: nxt_readdata = {8'h0, sumFf};
        default: nxt_readdata = 32'h0;
      endcase
    end
  end

  // Settings and conflict checks; a refused command leaves its setting unchanged, except a refused table enable, which turns that table off.
  always_comb begin
    nxt_avgEn = avgEnFf;
    nxt_stepDet = stepDetFf;
    nxt_vbwSel = vbwSelFf;
    nxt_vbwEn = vbwEnFf;
    nxt_bufCnt = bufCntFf;
    nxt_bufType = bufTypeFf;
    nxt_ofsTbl = ofsTblFf;
    nxt_gamTbl = gamTblFf;
    nxt_sglGam = sglGamFf;
    nxt_ctx = ctxFf;
    nxt_freqStep = freqStepFf;
    filtClear = 1'b0;
    errIn = '0;
    if (wrGo) begin
      unique case (address)
        `SASC_OFS_FILT_CLR: begin
          if (ctxFf.listMode) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_CONFLICT);
          end else begin
            filtClear = 1'b1;
          end
        end
        `SASC_OFS_STEP_DET: nxt_stepDet = writedata[0];
        `SASC_OFS_AVG_EN: begin
          if (writedata[0] && ctxFf.listMode) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_LIST_RUN);
          end else if (writedata[0] && ctxFf.rateFast) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_CONFLICT);
          end else begin
            nxt_avgEn = writedata[0];
          end
        end
        `SASC_OFS_VBW_SEL, `SASC_OFS_VBW_EN: begin
          if (ctxFf.detMean) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_CONFLICT);
          end else if (address == `SASC_OFS_VBW_SEL) begin
            nxt_vbwSel = sasc_vbw_t'(writedata[1:0]);
          end else begin
            nxt_vbwEn = writedata[0];
          end
        end
        `SASC_OFS_BUF_CNT: begin
          if (!ctxFf.trigExt) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_ACQ_MODE);
          end else if (freqStepFf != 16'h0) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_SWEEP);
          end else begin
            nxt_bufCnt = clipCount(writedata);
            if (clipCount(writedata) != writedata[15:0] || writedata[31:16] != 16'h0) begin
              errIn = mkErr(`SASC_ERR_CLIPPED, SASC_CAUSE_CLIPPED);
            end
          end
        end
        `SASC_OFS_BUF_TYPE: begin
          if (!ctxFf.trigExt || ctxFf.detMean) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_ACQ_MODE);
          end else if (writedata[31:2] != 30'h0) begin
            errIn = mkErr(`SASC_ERR_ILLEGAL, SASC_CAUSE_ILLEGAL);
          end else begin
            nxt_bufType = writedata[1:0];
          end
        end
        `SASC_OFS_OFS_TBL: begin
          if (writedata[0] && !ctxFf.ofsTblSel) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_CONFLICT);
            nxt_ofsTbl = 1'b0;
          end else begin
            nxt_ofsTbl = writedata[0];
          end
        end
        `SASC_OFS_GAM_TBL: begin
          if (writedata[0] && !ctxFf.gamTblSel) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_CONFLICT);
            nxt_gamTbl = 1'b0;
          end else begin
            nxt_gamTbl = writedata[0];
            if (writedata[0] && sglGamFf) begin
              nxt_sglGam = 1'b0;
              errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_SGL_OFF);
            end
          end
        end
        `SASC_OFS_SGL_GAM: begin
          // Keeps the two gamma corrections exclusive from this side too.
          if (writedata[0] && gamTblFf) begin
            errIn = mkErr(`SASC_ERR_CONFLICT, SASC_CAUSE_CONFLICT);
          end else begin
            nxt_sglGam = writedata[0];
          end
        end
        `SASC_OFS_CONTEXT: nxt_ctx = sasc_ctx_s'(writedata[8:0]);
        `SASC_OFS_FREQUENCY_STEP: nxt_freqStep = writedata[15:0];
        default: nxt_freqStep = freqStepFf;
      endcase
    end
    if (nxt_freqStep != 16'h0) begin
      nxt_bufCnt = clipCount({16'h0, nxt_freqStep});
    end
    nxt_vbwKhz = bwKhz(nxt_vbwSel);
  end

  // Settings registers; the two table enables deliberately ignore reset.
  always_ff @(posedge clk) begin
    if (reset) begin
      ackFf <= 1'b0;
      readdataFf <= 32'h0;
      stepDetFf <= 1'b1;
      avgEnFf <= 1'b1;
      vbwSelFf <= SASC_VBW_OFF;
      vbwEnFf <= 1'b0;
      vbwKhzFf <= `SASC_KHZ_HIGH;
      bufCntFf <= `SASC_BUF_MIN;
      bufTypeFf <= 2'h0;
      sglGamFf <= 1'b0;
      ctxFf <= sasc_ctx_s'(`SASC_CTX_RST);
      freqStepFf <= 16'h0;
    end else begin
      ackFf <= nxt_ack;
      readdataFf <= nxt_readdata;
      stepDetFf <= nxt_stepDet;
      avgEnFf <= nxt_avgEn;
      vbwSelFf <= nxt_vbwSel;
      vbwEnFf <= nxt_vbwEn;
      vbwKhzFf <= nxt_vbwKhz;
      bufCntFf <= nxt_bufCnt;
      bufTypeFf <= nxt_bufType;
      sglGamFf <= nxt_sglGam;
      ctxFf <= nxt_ctx;
      freqStepFf <= nxt_freqStep;
    end
  end

  always_ff @(posedge clk) begin
    ofsTblFf <= nxt_ofsTbl;
    gamTblFf <= nxt_gamTbl;
  end

  assign stepActive = stepDetFf && ctxFf.autoLength && !(ctxFf.autoTrigDelay && !ctxFf.contInit);

  // Compare mean of newest four against whole mean without dividing: cross-multiply.
  always_comb begin
    newest4 = 18'(lastFf[15:0]) + 18'(lastFf[31:16]) + 18'(lastFf[47:32]) + 18'(lastFf[63:48]);
    crossA = 28'(newest4) * 28'(cntFf);
    crossB = {2'h0, sumFf, 2'h0};
    crossDiff = (crossA > crossB) ? (crossA - crossB) : (crossB - crossA);
    stepHit = stepActive && (cntFf >= `SASC_STEP_MIN) && ({crossDiff[26:0], 1'b0} > 28'(sumFf));
  end

  // Filter history; a full filter leaks one entry's share so the sum stays bounded.
  always_comb begin
    nxt_sum = sumFf;
    nxt_cnt = cntFf;
    nxt_last = lastFf;
    if (filtClear || stepHit) begin
      nxt_sum = 24'h0;
      nxt_cnt = 9'h0;
      nxt_last = 64'h0;
    end
    if (sampleValid && avgEnFf) begin
      nxt_last = {nxt_last[47:0], sampleData};
      if (nxt_cnt == `SASC_FILT_MAX) begin
        nxt_sum = nxt_sum - (nxt_sum >> 8) + 24'(sampleData);
      end else begin
        nxt_sum = nxt_sum + 24'(sampleData);
        nxt_cnt = nxt_cnt + 9'h1;
      end
    end
  end

  // Filter registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      sumFf <= 24'h0;
      cntFf <= 9'h0;
      lastFf <= 64'h0;
    end else begin
      sumFf <= nxt_sum;
      cntFf <= nxt_cnt;
      lastFf <= nxt_last;
    end
  end

  always_comb begin
    pop = rdGo && (address == `SASC_OFS_ERR_POP) && (qCntFf != 4'h0);
    nxt_head = pop ? headFf + 3'h1 : headFf;
    // A full queue drops the newest error rather than overwrite an unread one.
    nxt_tail = (errIn.push && qCntFf != `SASC_QUEUE_DEPTH) ? tailFf + 3'h1 : tailFf;
    nxt_qCnt = qCntFf;
    if (errIn.push && qCntFf != `SASC_QUEUE_DEPTH && !pop) begin
      nxt_qCnt = qCntFf + 4'h1;
    end else if (pop && !(errIn.push && qCntFf != `SASC_QUEUE_DEPTH)) begin
      nxt_qCnt = qCntFf - 4'h1;
    end
  end

  // Queue pointer registers.
  always_ff @(posedge clk) begin
    if (reset) begin
      headFf <= 3'h0;
      tailFf <= 3'h0;
      qCntFf <= 4'h0;
    end else begin
      headFf <= nxt_head;
      tailFf <= nxt_tail;
      qCntFf <= nxt_qCnt;
    end
  end

  // The memory reads the next head so the front entry is ready for the next request.
  assign memBus.wrEn = errIn.push && (qCntFf != `SASC_QUEUE_DEPTH);
  assign memBus.wrAddr = tailFf;
  assign memBus.wrData = {errIn.cause, errIn.code};
  assign memBus.rdAddr = nxt_head;

  sasc_err_mem uMem (
    .clk(clk),
    .m(memBus)
  );

  assign firFilterOn = (vbwSelFf != SASC_VBW_OFF);
  assign correctionBypass = (vbwSelFf == SASC_VBW_OFF);
  assign readdata = readdataFf;
  assign filterSum = sumFf;
  assign filterCount = cntFf;
  assign avgOn = avgEnFf;
  assign vbwKhz = vbwKhzFf;
  assign videoBwOn = vbwEnFf;
  assign bufCount = bufCntFf;
  assign bufType = bufTypeFf;
  assign offsetTableOn = ofsTblFf;
  assign gammaTableOn = gamTblFf;
  assign singleGammaOn = sglGamFf;

  // Checks on the settings logic.
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_clr_empties: assert property (
    wrGo && address == `SASC_OFS_FILT_CLR && !ctxFf.listMode |=> cntFf <= 9'h1)
    else $error("filter not emptied by clear");
  a_clr_list_err: assert property (
    wrGo && address == `SASC_OFS_FILT_CLR && ctxFf.listMode
      |-> errIn.push && errIn.code == `SASC_ERR_CONFLICT && !filtClear)
    else $error("clear in list mode not refused");
  a_step_clears: assert property (
    stepHit |=> cntFf <= 9'h1)
    else $error("step did not clear filter");
  a_step_masked: assert property (
    ctxFf.autoTrigDelay && !ctxFf.contInit && !(wrGo && address == `SASC_OFS_STEP_DET)
      |-> !stepActive ##1 $stable(stepDetFf))
    else $error("step detection not masked");
  a_avg_fast: assert property (
    wrGo && address == `SASC_OFS_AVG_EN && writedata[0] && ctxFf.rateFast && !avgEnFf
      |=> !avgEnFf && qCntFf != 4'h0)
    else $error("averaging on at fast rate");
  a_vbw_map: assert property (
    vbwSelFf == SASC_VBW_MED ##1 vbwSelFf == SASC_VBW_MED |-> vbwKhz == `SASC_KHZ_MED)
    else $error("bandwidth figure wrong");
  a_vbw_det_mean: assert property (
    wrGo && ctxFf.detMean && (address == `SASC_OFS_VBW_SEL || address == `SASC_OFS_VBW_EN)
      |=> $stable(vbwSelFf) && $stable(vbwEnFf))
    else $error("bandwidth changed under mean detection");
  a_buf_range: assert property (
    bufCntFf >= `SASC_BUF_MIN && bufCntFf <= `SASC_BUF_MAX)
    else $error("buffer count out of range");
  a_ofs_stays_off: assert property (
    wrGo && address == `SASC_OFS_OFS_TBL && !ctxFf.ofsTblSel |=> !ofsTblFf)
    else $error("offset table on without table");
  a_gamma_exclusive: assert property (
    !(gamTblFf && sglGamFf))
    else $error("both gamma corrections on");
  a_queue_count: assert property (
    errIn.push && !pop && qCntFf < `SASC_QUEUE_DEPTH |=> qCntFf == $past(qCntFf) + 4'h1)
    else $error("error not queued");

  c_step_hit: cover property (stepHit);
  c_conflict: cover property (errIn.push && errIn.code == `SASC_ERR_CONFLICT);
  c_clip: cover property (errIn.push && errIn.code == `SASC_ERR_CLIPPED);
  c_pop: cover property (pop);
endmodule : sasc_top

// [tb/sasc_host.sv]
// Avalon host model that issues register reads and writes.
`timescale 1ns/10ps
module sasc_host (
  input wire logic clk, // System clock.
  output logic [7:0] address, // Byte address.
  output logic read, // Read request.
  output logic write, // Write request.
  output logic [31:0] writedata, // Write data.
  input wire logic [31:0] readdata, // Read data.
  input wire logic waitrequest // Slave stall.
);
  initial begin
    address = 8'h00;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
  end
  // Hold the request until waitrequest is seen low at a rising edge; data are taken there.
  task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    @(posedge clk);
    while (waitrequest) begin
      @(posedge clk);
    end
    q = readdata;
    write <= 1'b0;
    read <= 1'b0;
    @(posedge clk);
  endtask : acc
endmodule : sasc_host

// [tb/test_sensor_averaging_setup_control.sv]
// Self-checking bench of the averaging setup controller.
`timescale 1ns/10ps
module test_sensor_averaging_setup_control;
  logic clk, reset, read, write, waitrequest, avgOn, stepActive, firFilterOn;
  logic correctionBypass, videoBwOn, offsetTableOn, gammaTableOn, singleGammaOn;
  logic [7:0] address;
  logic [31:0] writedata, readdata, q, v;
  logic [23:0] filterSum;
  logic [8:0] filterCount;
  logic [12:0] vbwKhz;
  logic [15:0] bufCount;
  logic [1:0] bufType;
  logic sampleValid = 1'b0;
  logic sampOn = 1'b1;
  logic [15:0] sampleData = 16'h0;
  logic fixOn = 1'b0;
  logic [15:0] fixVal = 16'h0;
  logic [31:0] lfsr = 32'hf327;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  sasc_top i_dut (.clk, .reset, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .sampleValid, .sampleData, .filterSum, .filterCount, .avgOn,
    .stepActive, .firFilterOn, .correctionBypass, .vbwKhz, .videoBwOn, .bufCount,
    .bufType, .offsetTableOn, .gammaTableOn, .singleGammaOn);
  sasc_host i_host (.clk, .address, .read, .write, .writedata, .readdata,
    .waitrequest);
  function automatic logic [31:0] nxtRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxtRand
  function automatic logic [31:0] clipCnt(input logic [31:0] x);
    return (x < 32'h1) ? 32'h1 : (x > 32'hea61) ? 32'hea61 : x;
  endfunction : clipCnt
  function automatic logic [31:0] khz(input int s);
    return (s == 1) ? 32'h12c : (s == 2) ? 32'h5dc : 32'h1388;
  endfunction : khz
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    i_host.acc(1'b1, a, d, q);
  endtask : wreg
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    i_host.acc(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask : rchk
  // Pops the oldest queue entry; the queue must hand entries back in order.
  task automatic err(input logic [3:0] c, input logic [15:0] code);
    rchk("errEntry", 8'h30, {12'h0, c, code});
  endtask : err
  task automatic summarize;
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // Random measurements keep the filter busy; sampOn pauses them, fixOn plays a fixed level.
  always @(posedge clk) begin
    lfsr <= nxtRand(lfsr);
    sampleValid <= (lfsr[0] & sampOn) | fixOn;
    sampleData <= fixOn ? fixVal : lfsr[23:8];
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    rchk("stepDet", 8'h04, 32'h1);
    rchk("avgEn", 8'h08, 32'h1);
    rchk("vbwSel", 8'h0c, 32'h0);
    rchk("vbwEn", 8'h10, 32'h0);
    rchk("bufCnt", 8'h14, 32'h1);
    rchk("bufType", 8'h18, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wreg(8'h0c, 32'(s));
      rchk("vbwKhz", 8'h38, khz(s));
      chk("vbwPort", khz(s), 32'(vbwKhz));
      chk("fir", 32'(s != 0), 32'(firFilterOn));
      chk("bypass", 32'(s == 0), 32'(correctionBypass));
    end
    wreg(8'h10, 32'h1);
    wreg(8'h28, 32'h044);
    wreg(8'h10, 32'h0);
    wreg(8'h0c, 32'h1);
    err(4'h1, 16'hff23);
    err(4'h1, 16'hff23);
    chk("vbwOn", 32'h1, 32'(videoBwOn));
    wreg(8'h28, 32'h024);
    for (int k = 0; k < 8; k++) begin
      v = (k == 0) ? 32'h0 : (k == 1) ? 32'hea62 : (k == 2) ? 32'hea61 : lfsr % 32'h11000;
      wreg(8'h14, v);
      chk("bufPort", clipCnt(v), 32'(bufCount));
      if (v == 32'h0 || v > 32'hea61) err(4'h6, 16'hff22);
    end
    wreg(8'h28, 32'h004);
    wreg(8'h14, 32'h7);
    wreg(8'h28, 32'h024);
    wreg(8'h2c, 32'h5);
    wreg(8'h14, 32'h9);
    chk("bufSweep", 32'h5, 32'(bufCount));
    i_host.acc(1'b0, 8'h34, 32'h0, q);
    chk("queueCount", 32'h2, 32'(q[3:0]));
    err(4'h3, 16'hff23);
    err(4'h4, 16'hff23);
    wreg(8'h2c, 32'h0);
    wreg(8'h18, 32'h4);
    err(4'h7, 16'hff20);
    for (int t = 3; t >= 0; t--) begin
      wreg(8'h18, 32'(t));
      rchk("bufType", 8'h18, 32'(t));
      chk("typePort", 32'(t), 32'(bufType));
    end
    wreg(8'h28, 32'h064);
    wreg(8'h18, 32'h1);
    err(4'h3, 16'hff23);
    wreg(8'h28, 32'h004);
    wreg(8'h08, 32'h0);
    wreg(8'h28, 32'h084);
    wreg(8'h08, 32'h1);
    err(4'h1, 16'hff23);
    wreg(8'h28, 32'h104);
    wreg(8'h08, 32'h1);
    err(4'h2, 16'hff23);
    chk("avgOn", 32'h0, 32'(avgOn));
    wreg(8'h00, 32'h0);
    err(4'h1, 16'hff23);
    for (int m = 0; m < 2; m++) begin
      wreg(8'h28, m ? 32'h000 : 32'h004);
      wreg(8'h08, 32'h1);
      sampOn <= 1'b1;
      repeat (30) @(posedge clk);
      sampOn <= 1'b0;
      repeat (3) @(posedge clk);
      wreg(8'h00, 32'h0);
      chk("filtCount", 32'h0, 32'(filterCount));
      chk("filtSum", 32'h0, 32'(filterSum));
    end
    // A jump from a steady level by far more than one eighth must restart the history.
    wreg(8'h28, 32'h004);
    fixVal <= 16'h1000;
    fixOn <= 1'b1;
    repeat (8) @(posedge clk);
    fixVal <= 16'h3000;
    repeat (2) @(posedge clk);
    fixOn <= 1'b0;
    repeat (2) @(posedge clk);
    chk("stepClr", 32'h1, 32'(filterCount));
    chk("stepSum", 32'h3000, 32'(filterSum));
    wreg(8'h28, 32'h014);
    chk("stepMask", 32'h0, 32'(stepActive));
    rchk("stepDet", 8'h04, 32'h1);
    wreg(8'h28, 32'h004);
    wreg(8'h1c, 32'h1);
    err(4'h1, 16'hff23);
    wreg(8'h20, 32'h1);
    err(4'h1, 16'hff23);
    chk("tblOff", 32'h0, 32'({offsetTableOn, gammaTableOn}));
    wreg(8'h28, 32'h007);
    wreg(8'h24, 32'h1);
    wreg(8'h20, 32'h1);
    wreg(8'h1c, 32'h1);
    err(4'h5, 16'hff23);
    chk("gamma", 32'h3, 32'({singleGammaOn, gammaTableOn, offsetTableOn}));
    reset <= 1'b1;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("tblKeep", 32'h3, 32'({gammaTableOn, offsetTableOn}));
    summarize();
  end
endmodule : test_sensor_averaging_setup_control
